// ### rtl/serial_port_pkg.sv
package serial_port_pkg;

  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned RATE_LOW_BPS = 9600;
  localparam int unsigned RATE_MID_BPS = 19200;
  localparam int unsigned RATE_HIGH_BPS = 38400;
  localparam int unsigned CYC_LOW = CLK_HZ / RATE_LOW_BPS;
  localparam int unsigned CYC_MID = CLK_HZ / RATE_MID_BPS;
  localparam int unsigned CYC_HIGH = CLK_HZ / RATE_HIGH_BPS;
  localparam int CNT_W = 16;

  localparam logic [3:0] OFS_TX_DATA = 4'h0;
  localparam logic [3:0] OFS_RX_DATA = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam logic [3:0] OFS_CONFIG = 4'hc;
  localparam int ADDR_W = 4;

  localparam int ST_TX_BUSY = 0;
  localparam int ST_RX_VALID = 1;
  localparam int ST_PARITY_ERR = 2;
  localparam int ST_FRAME_ERR = 3;
  localparam int ST_OVERRUN = 4;
  localparam int ST_SELECTED = 5;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [3:0] SEL_CODE_HIGH = 4'h1;
  localparam logic [2:0] LAST_BIT_8 = 3'h7;
  localparam logic [2:0] LAST_BIT_7 = 3'h6;
  localparam logic [1:0] RATE_MID = 2'h1;
  localparam logic [1:0] RATE_HIGH = 2'h2;

  typedef struct packed {
    logic [3:0] unit_number;
    logic [1:0] rate;
    logic one_stop;
    logic parity_odd;
    logic parity_off;
    logic data7;
  } port_cfg_t;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_START = 5'b00010,
    S_DATA = 5'b00100,
    S_PARITY = 5'b01000,
    S_STOP = 5'b10000
  } line_state_t;

endpackage : serial_port_pkg

// ### rtl/multidrop_serial_port.sv
// Our own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module multidrop_serial_port
  import serial_port_pkg::*;
#(
  parameter int unsigned BIT_CYC_LOW = serial_port_pkg::CYC_LOW,
  parameter int unsigned BIT_CYC_MID = serial_port_pkg::CYC_MID,
  parameter int unsigned BIT_CYC_HIGH = serial_port_pkg::CYC_HIGH
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [serial_port_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [serial_port_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sw_data7,
  input wire logic sw_parity_off,
  input wire logic sw_parity_odd,
  input wire logic sw_one_stop,
  input wire logic rate_select_high,
  input wire logic rate_select_low,
  input wire logic [3:0] unit_number,
  input wire logic rxd,
  output logic txd,
  output logic txd_oe
);
  import serial_port_pkg::*;

  function automatic logic [CNT_W-1:0] bit_cycles(input logic [1:0] rate);
    logic [CNT_W-1:0] c;
    c = CNT_W'(BIT_CYC_LOW - 1);
    if (rate == RATE_MID)
      c = CNT_W'(BIT_CYC_MID - 1);
    else if (rate == RATE_HIGH)
      c = CNT_W'(BIT_CYC_HIGH - 1);
    return c;
  endfunction : bit_cycles

  function automatic logic parity_of(input logic [7:0] d, input port_cfg_t c);
    logic p;
    p = c.data7 ? ^d[6:0] : ^d;
    return c.parity_odd ? ~p : p;
  endfunction : parity_of

  port_cfg_t cfg, next_cfg;
  logic captured, next_captured;
  logic [CNT_W-1:0] bit_len;
  logic [2:0] last_bit;

  always_comb
  begin
    next_cfg = cfg;
    next_captured = 1'b1;
    if (!captured)
    begin
      next_cfg.data7 = sw_data7;
      next_cfg.parity_off = sw_parity_off;
      next_cfg.parity_odd = sw_parity_odd;
      next_cfg.one_stop = sw_one_stop;
      next_cfg.rate = {rate_select_high, rate_select_low};
      next_cfg.unit_number = unit_number;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg <= '0;
      captured <= 1'b0;
    end
    else
    begin
      cfg <= next_cfg;
      captured <= next_captured;
    end
  end

  assign bit_len = bit_cycles(cfg.rate);
  assign last_bit = cfg.data7 ? LAST_BIT_7 : LAST_BIT_8;

  // transmitter
  line_state_t tx_state, next_tx_state;
  logic [CNT_W-1:0] tx_cnt, next_tx_cnt;
  logic [2:0] tx_idx, next_tx_idx;
  logic [7:0] tx_shift, next_tx_shift;
  logic tx_second, next_tx_second;
  logic next_txd;
  logic tx_load;
  logic [7:0] tx_load_data;
  logic selected, next_selected;

  always_comb
  begin
    next_tx_state = tx_state;
    next_tx_cnt = (tx_cnt == '0) ? '0 : tx_cnt - 1'b1;
    next_tx_idx = tx_idx;
    next_tx_shift = tx_shift;
    next_tx_second = tx_second;
    next_txd = txd;
    unique case (tx_state)
      S_IDLE:
      begin
        next_txd = 1'b1;
        if (tx_load)
        begin
          next_tx_state = S_START;
          next_tx_shift = tx_load_data;
          next_tx_cnt = bit_len;
          next_txd = 1'b0;
        end
      end
      S_START, S_DATA, S_PARITY:
        if (tx_cnt == '0)
        begin
          next_tx_cnt = bit_len;
          next_tx_idx = (tx_state == S_DATA) ? tx_idx + 1'b1 : '0;
          if (tx_state == S_START || (tx_state == S_DATA && tx_idx != last_bit))
          begin
            next_tx_state = S_DATA;
            next_txd = (tx_state == S_START) ? tx_shift[0] : tx_shift[tx_idx + 1'b1];
          end
          else if (tx_state == S_DATA && !cfg.parity_off)
          begin
            next_tx_state = S_PARITY;
            next_txd = parity_of(tx_shift, cfg);
          end
          else
          begin
            next_tx_state = S_STOP;
            next_tx_second = !cfg.one_stop;
            next_txd = 1'b1;
          end
        end
      S_STOP:
        if (tx_cnt == '0)
        begin
          next_tx_cnt = bit_len;
          next_tx_second = 1'b0;
          if (!tx_second)
            next_tx_state = S_IDLE;
        end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_state <= S_IDLE;
      tx_cnt <= '0;
      tx_idx <= '0;
      tx_shift <= '0;
      tx_second <= 1'b0;
      txd <= 1'b1;
    end
    else
    begin
      tx_state <= next_tx_state;
      tx_cnt <= next_tx_cnt;
      tx_idx <= next_tx_idx;
      tx_shift <= next_tx_shift;
      tx_second <= next_tx_second;
      txd <= next_txd;
    end
  end

  assign txd_oe = (tx_state != S_IDLE);

  // receiver
  line_state_t rx_state, next_rx_state;
  logic [CNT_W-1:0] rx_cnt, next_rx_cnt;
  logic [2:0] rx_idx, next_rx_idx;
  logic [7:0] rx_shift, next_rx_shift;
  logic rx_par_bad, next_rx_par_bad;
  logic rx_done, rx_frame_bad;

  always_comb
  begin
    next_rx_state = rx_state;
    next_rx_cnt = (rx_cnt == '0) ? '0 : rx_cnt - 1'b1;
    next_rx_idx = rx_idx;
    next_rx_shift = rx_shift;
    next_rx_par_bad = rx_par_bad;
    rx_done = 1'b0;
    rx_frame_bad = 1'b0;
    unique case (rx_state)
      S_IDLE:
        if (!rxd && captured)
        begin
          next_rx_state = S_START;
          next_rx_cnt = {1'b0, bit_len[CNT_W-1:1]};
        end
      S_START:
        if (rx_cnt == '0)
        begin
          next_rx_state = rxd ? S_IDLE : S_DATA;
          next_rx_cnt = bit_len;
          next_rx_idx = '0;
          next_rx_shift = '0;
          next_rx_par_bad = 1'b0;
        end
      S_DATA:
        if (rx_cnt == '0)
        begin
          next_rx_cnt = bit_len;
          next_rx_shift[rx_idx] = rxd;
          next_rx_idx = rx_idx + 1'b1;
          if (rx_idx == last_bit)
            next_rx_state = cfg.parity_off ? S_STOP : S_PARITY;
        end
      S_PARITY:
        if (rx_cnt == '0)
        begin
          next_rx_cnt = bit_len;
          next_rx_par_bad = (rxd != parity_of(rx_shift, cfg));
          next_rx_state = S_STOP;
        end
      S_STOP:
        if (rx_cnt == '0)
        begin
          next_rx_state = S_IDLE;
          rx_done = 1'b1;
          rx_frame_bad = !rxd;
        end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_state <= S_IDLE;
      rx_cnt <= '0;
      rx_idx <= '0;
      rx_shift <= '0;
      rx_par_bad <= 1'b0;
    end
    else
    begin
      rx_state <= next_rx_state;
      rx_cnt <= next_rx_cnt;
      rx_idx <= next_rx_idx;
      rx_shift <= next_rx_shift;
      rx_par_bad <= next_rx_par_bad;
    end
  end

  // register file and axi4-lite slave
  logic [7:0] rx_data, next_rx_data;
  logic rx_valid, next_rx_valid;
  logic [4:2] sticky, next_sticky;
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic wr_go, rd_go, sel_code, rx_take;

  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready = !w_held && !bvalid;
  assign s_axi_arready = !rvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rresp = rresp;
  assign s_axi_rdata = rdata;
  assign wr_go = aw_held && w_held && !bvalid;
  assign rd_go = s_axi_arvalid && !rvalid;
  assign tx_load = wr_go && aw_addr == OFS_TX_DATA && w_strb[0] && selected;
  assign tx_load_data = cfg.data7 ? {1'b0, w_data[6:0]} : w_data[7:0];
  assign sel_code = (rx_shift[7:4] == SEL_CODE_HIGH);
  assign rx_take = rx_done && !rx_frame_bad && !rx_par_bad;

  always_comb
  begin
    next_aw_held = aw_held || (s_axi_awvalid && s_axi_awready);
    next_w_held = w_held || (s_axi_wvalid && s_axi_wready);
    next_aw_addr = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_addr;
    next_w_data = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : w_data;
    next_w_strb = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : w_strb;
    next_bvalid = bvalid && !s_axi_bready;
    next_bresp = bresp;
    next_rvalid = rvalid && !s_axi_rready;
    next_rresp = rresp;
    next_rdata = rdata;
    next_rx_data = rx_data;
    next_rx_valid = rx_valid;
    next_sticky = sticky;
    next_selected = selected;
    if (wr_go)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = (aw_addr == OFS_TX_DATA || aw_addr == OFS_STATUS) ? RESP_OKAY : RESP_SLVERR;
      if (aw_addr == OFS_STATUS && w_strb[0])
        next_sticky = sticky & ~w_data[ST_OVERRUN:ST_PARITY_ERR];
    end
    if (rd_go)
    begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      next_rdata = '0;
      unique case (s_axi_araddr)
        OFS_RX_DATA:
        begin
          next_rdata[7:0] = rx_data;
          next_rx_valid = 1'b0;
        end
        OFS_STATUS:
          next_rdata[ST_SELECTED:ST_TX_BUSY] = {selected, sticky, rx_valid, txd_oe};
        OFS_CONFIG:
          next_rdata[$bits(port_cfg_t)-1:0] = cfg;
        default:
          next_rresp = RESP_SLVERR;
      endcase
    end
    if (rx_done)
    begin
      next_sticky[ST_FRAME_ERR] = next_sticky[ST_FRAME_ERR] | rx_frame_bad;
      next_sticky[ST_PARITY_ERR] = next_sticky[ST_PARITY_ERR] | rx_par_bad;
    end
    if (rx_take && sel_code)
      next_selected = (rx_shift[3:0] == cfg.unit_number);
    else if (rx_take && selected)
    begin
      next_rx_data = rx_shift;
      next_rx_valid = 1'b1;
      next_sticky[ST_OVERRUN] = next_sticky[ST_OVERRUN] | rx_valid;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= '0;
      rx_data <= '0;
      rx_valid <= 1'b0;
      sticky <= '0;
      selected <= 1'b0;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      rx_data <= next_rx_data;
      rx_valid <= next_rx_valid;
      sticky <= next_sticky;
      selected <= next_selected;
    end
  end

endmodule : multidrop_serial_port

// ### tb/serial_port_properties.sv
`timescale 1ns/1ps
module serial_port_properties
  import serial_port_pkg::*;
#(
  parameter int unsigned BIT_CYC_LOW = CYC_LOW,
  parameter int unsigned BIT_CYC_MID = CYC_MID,
  parameter int unsigned BIT_CYC_HIGH = CYC_HIGH
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sw_data7,
  input wire logic sw_parity_off,
  input wire logic sw_one_stop,
  input wire logic rate_select_high,
  input wire logic rate_select_low,
  input wire logic txd,
  input wire logic txd_oe
);
  int unsigned bit_cyc;
  int unsigned frame_cyc;
  int unsigned oe_cnt;
  assign bit_cyc = (rate_select_high && !rate_select_low) ? BIT_CYC_HIGH :
    (rate_select_low && !rate_select_high) ? BIT_CYC_MID : BIT_CYC_LOW;
  assign frame_cyc = bit_cyc * (11 - sw_data7 + !sw_parity_off - sw_one_stop);
  always_ff @(posedge aclk) oe_cnt <= (aresetn && txd_oe) ? oe_cnt + 1 : 0;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_frame_start;
    $rose(txd_oe);
  endsequence
  sequence s_frame_end;
    $fell(txd_oe);
  endsequence
  a_line_idle: assert property (!txd_oe |-> txd)
    else $error("line not idle high");
  a_start_bit: assert property (s_frame_start |-> !txd [*4])
    else $error("start bit not low");
  a_stop_bit: assert property (s_frame_end |-> $past(txd))
    else $error("stop bit not high");
  a_frame_len: assert property (s_frame_end |-> oe_cnt == frame_cyc)
    else $error("frame length wrong");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read answer dropped");
endmodule : serial_port_properties
bind multidrop_serial_port serial_port_properties #(.BIT_CYC_LOW(BIT_CYC_LOW),
  .BIT_CYC_MID(BIT_CYC_MID), .BIT_CYC_HIGH(BIT_CYC_HIGH)) u_props (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .sw_data7, .sw_parity_off, .sw_one_stop,
  .rate_select_high, .rate_select_low, .txd, .txd_oe);

// ### tb/host_pc_model.sv
`timescale 1ns/1ps
module host_pc_model
(
  input wire logic aclk,
  input wire logic txd,
  output logic rxd
);
  int unsigned bit_cyc = 16;
  logic data7 = 1'h0;
  logic par_on = 1'h0;
  logic par_odd = 1'h0;
  logic one_stop = 1'h0;
  logic [7:0] got = 8'h00;
  logic got_err = 1'h0;
  int got_n = 0;
  initial rxd = 1'h1;
  task automatic hold_bit(input logic b);
    rxd <= b;
    repeat (bit_cyc) @(posedge aclk);
  endtask : hold_bit
  task automatic send(input logic [7:0] c, input logic bad);
    hold_bit(1'h0);
    for (int i = 0; i < 8 - data7; i++) hold_bit(c[i]);
    if (par_on) hold_bit(^c[6:0] ^ (c[7] & !data7) ^ par_odd ^ bad);
    hold_bit(1'h1);
    if (!one_stop) hold_bit(1'h1);
  endtask : send
  initial forever
  begin
    @(negedge txd);
    repeat (bit_cyc / 2) @(posedge aclk);
    got = 8'h00;
    for (int i = 0; i < 8 - data7; i++)
    begin
      repeat (bit_cyc) @(posedge aclk);
      got[i] = txd;
    end
    got_err = 1'h0;
    if (par_on)
    begin
      repeat (bit_cyc) @(posedge aclk);
      got_err = txd ^ (^got) ^ par_odd;
    end
    repeat (bit_cyc) @(posedge aclk);
    got_err = got_err | !txd;
    got_n++;
  end
endmodule : host_pc_model

// ### tb/multidrop_serial_port_tb_top.sv
`timescale 1ns/1ps
module multidrop_serial_port_tb_top;
  import serial_port_pkg::*;
  logic aclk = 1'h0, aresetn = 1'h0, rxd, txd, txd_oe;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic sw_data7 = 1'h0, sw_parity_off = 1'h0, sw_parity_odd = 1'h0, sw_one_stop = 1'h0;
  logic rate_select_high = 1'h0, rate_select_low = 1'h0;
  logic [3:0] unit_number = 4'h0;
  logic [7:0] d, t;
  port_cfg_t cfg;
  int n_mismatch = 0, cmp_count = 0, n0;
  multidrop_serial_port #(.BIT_CYC_LOW(16), .BIT_CYC_MID(8), .BIT_CYC_HIGH(4)) dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sw_data7, .sw_parity_off,
    .sw_parity_odd, .sw_one_stop, .rate_select_high, .rate_select_low, .unit_number,
    .rxd, .txd, .txd_oe);
  host_pc_model host (.aclk, .txd, .rxd);
  always #2.5 aclk = ~aclk;
  function automatic int unsigned exp_cyc(input logic [1:0] rate);
    return (rate == RATE_MID) ? 8 : (rate == RATE_HIGH) ? 4 : 16;
  endfunction : exp_cyc
  function automatic logic [31:0] exp_char(input logic [7:0] c, input logic d7);
    return {24'h0, c & (d7 ? 8'h7f : 8'hff)};
  endfunction : exp_char
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick_limit(input int n);
    if (n > 999)
    begin
      n_mismatch++;
      end_of_test();
    end
  endtask : tick_limit
  task automatic axi(input logic wr, input logic [3:0] a, input logic [31:0] wd,
    output logic [31:0] q, output logic [1:0] rs);
    int n;
    logic done;
    logic rb;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= wd;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_arvalid <= !wr;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      done = wr ? s_axi_bvalid && s_axi_bready : s_axi_rvalid && s_axi_rready;
      q = s_axi_rdata;
      rs = wr ? s_axi_bresp : s_axi_rresp;
      rb = 1'($urandom_range(1));
      s_axi_bready <= wr && !done && (s_axi_bready || rb);
      s_axi_rready <= !wr && !done && (s_axi_rready || rb);
      n++;
      tick_limit(n);
    end
    while (!done);
  endtask : axi
  task automatic wait_char(input int k);
    for (int n = 0; host.got_n == k; n++)
    begin
      @(posedge aclk);
      tick_limit(n);
    end
  endtask : wait_char
  initial
  begin
    void'($urandom(32'hec52));
    for (int k = 0; k < 6; k++)
    begin
      cfg = (k == 0) ? 10'h3f5 : (k == 1) ? 10'h028 : 10'($urandom);
      aresetn <= 1'h0;
      sw_data7 <= cfg.data7;
      sw_parity_off <= cfg.parity_off;
      sw_parity_odd <= cfg.parity_odd;
      sw_one_stop <= cfg.one_stop;
      {rate_select_high, rate_select_low} <= cfg.rate;
      unit_number <= cfg.unit_number;
      host.bit_cyc = exp_cyc(cfg.rate);
      host.data7 = cfg.data7;
      host.par_on = !cfg.parity_off;
      host.par_odd = cfg.parity_odd;
      host.one_stop = cfg.one_stop;
      repeat (3) @(posedge aclk);
      aresetn <= 1'h1;
      repeat (2) @(posedge aclk);
      axi(1'h0, OFS_CONFIG, 32'h0, v, r);
      check(v, {22'h0, cfg});
      host.send({4'h1, cfg.unit_number}, 1'h0);
      axi(1'h0, OFS_STATUS, 32'h0, v, r);
      check(v & 32'h20, 32'h20);
      d = 8'h20 + 8'($urandom_range(32'h5e));
      t = 8'h20 + 8'($urandom_range(32'h5e));
      n0 = host.got_n;
      fork
        host.send(d, 1'h0);
        axi(1'h1, OFS_TX_DATA, {24'h0, t}, v, r);
      join
      wait_char(n0);
      check({24'h0, host.got}, exp_char(t, cfg.data7));
      check({31'h0, host.got_err}, 32'h0);
      axi(1'h0, OFS_RX_DATA, 32'h0, v, r);
      check(v, exp_char(d, cfg.data7));
      host.send(t, 1'h1);
      axi(1'h0, OFS_STATUS, 32'h0, v, r);
      check(v & 32'h6, {29'h0, !cfg.parity_off, cfg.parity_off, 1'h0});
      axi(1'h1, OFS_STATUS, 32'h1c, v, r);
      check({30'h0, r}, {30'h0, RESP_OKAY});
      host.send({4'h1, cfg.unit_number + 4'h1}, 1'h0);
      axi(1'h0, OFS_STATUS, 32'h0, v, r);
      check(v & 32'h20, 32'h0);
      check(v & 32'h1e, {30'h0, cfg.parity_off, 1'h0});
      axi(1'h0, OFS_TX_DATA, 32'h0, v, r);
      check({30'h0, r}, {30'h0, RESP_SLVERR});
      axi(1'h1, OFS_CONFIG, 32'h0, v, r);
      check({30'h0, r}, {30'h0, RESP_SLVERR});
      sw_data7 <= !cfg.data7;
      unit_number <= ~cfg.unit_number;
      rate_select_low <= !cfg.rate[0];
      axi(1'h0, OFS_CONFIG, 32'h0, v, r);
      check(v, {22'h0, cfg});
      $display("config %0d done", k);
    end
    end_of_test();
  end
endmodule : multidrop_serial_port_tb_top
